/* File: pkg/cspc_regs.svh */
`ifndef CSPC_REGS_SVH
`define CSPC_REGS_SVH
// register byte offsets
`define CSPC_CTRL 6'h00
`define CSPC_STAT 6'h04
`define CSPC_DIV0 6'h08
`define CSPC_DIV_STEP 6'h04
`define CSPC_FRAC 6'h18
`define CSPC_FB 6'h1c
`define CSPC_FINE 6'h20
// control fields
`define CSPC_CTRL_RST 0
`define CSPC_CTRL_INTFB 1
`define CSPC_CTRL_FINE 2
`define CSPC_CTRL_RV 3'h1
// divider word fields
`define CSPC_DIV_LSB 0
`define CSPC_HIGH_LSB 8
`define CSPC_TAP_LSB 16
`define CSPC_DLY_LSB 24
`define CSPC_DIV_RV 32'h0000_0102
`define CSPC_FB_RV 32'h0000_0008
// fraction fields
`define CSPC_FRAC_EN 3
`define CSPC_FRAC_RV 4'h0
// timing
`define CSPC_CLK_MHZ 20
`define CSPC_STOP_TIME_NS 1600
`define CSPC_STOP_CYC (`CSPC_STOP_TIME_NS * `CSPC_CLK_MHZ / 1000)
`define CSPC_LOCK_EDGES 16
`define CSPC_TAPS 8
`endif

/* File: pkg/cspc_pkg.sv */
`default_nettype none
package cspc_pkg;
    // one output or feedback counter setting
    typedef struct packed {
        logic [7:0] dly;
        logic [2:0] tap;
        logic [7:0] high;
        logic [7:0] div;
    } cspc_div_cfg_t;
    // lock acquisition states
    typedef enum logic [1:0] {
        CSPC_ACQ = 2'b00,
        CSPC_LOCK_INDICATION = 2'b01,
        CSPC_LOST = 2'b10
    } cspc_lock_t;
    // clock health as seen by status
    typedef struct packed {
        logic fb_stop;
        logic in_stop;
    } cspc_stop_t;
endpackage
`default_nettype wire

/* File: hdl/cspc_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cspc_regs.svh"
// Contract
// - eight oscillator phase taps exist and every divider may pick any one of them.
// - after start-up the taps start strictly in phase order, tap 0 first.
// - a divide-by-two on the 180-degree tap lags one on tap 0 by half an oscillator period.
// - dividers support odd integer ratios with high time set by the duty field.
// - a divider delay may span many oscillator periods, e.g. a whole output cycle.
// - all dividers share the integer features and only the primary one does fractional division.
// - the reference select drives the input mux directly with no synchroniser.
// - stopped flags rise when the reference or feedback clock disappears.
// - lock drops whenever the reference or feedback clock is lost.
// - the input stopped flag clears when the clock returns, and lock returns only after a reset.
// - in deskew mode the feedback counter setting sets the input to output phase.
// - an internal feedback mode exists that keeps no fixed input to output phase.
// - the fine phase shift always starts at zero and cannot be preset.
module cspc_top import cspc_pkg::*; #(
    parameter int unsigned STOP_CYC = `CSPC_STOP_CYC,
    parameter int unsigned LOCK_EDGES = `CSPC_LOCK_EDGES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // avalon-mm slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // reference and feedback pins
    input wire logic reference_clock_input0_i,
    input wire logic reference_clock_input1_i,
    input wire logic ref_clock_select_i,
    input wire logic feedback_clock_in_i,
    // synthesized clocks and status
    output logic [7:0] osc_tap_o,
    output logic [3:0] output_divider_clk_o,
    output logic feedback_clock_out_o,
    output logic lock_indication_o,
    output logic input_clock_stopped_flag_o,
    output logic feedback_clock_stopped_flag_o
);
    if (STOP_CYC < 2 || STOP_CYC > 65535 || LOCK_EDGES < 1 || LOCK_EDGES > 65535) begin : g_chk
        $error("cspc_top: unsupported STOP_CYC or LOCK_EDGES");
    end

    // decode a divider word into its fields
    function automatic cspc_div_cfg_t cfg_of(input logic [31:0] w);
        cfg_of = '{dly: w[`CSPC_DLY_LSB +: 8], tap: w[`CSPC_TAP_LSB +: 3],
                   high: w[`CSPC_HIGH_LSB +: 8], div: w[`CSPC_DIV_LSB +: 8]};
    endfunction
    // byte offset of counter n, index 4 being the feedback counter
    function automatic logic [5:0] div_addr(input int n);
        div_addr = (n == 4) ? `CSPC_FB : 6'(`CSPC_DIV0 + n * `CSPC_DIV_STEP);
    endfunction

    logic wait_r;
    logic [31:0] rdata_r;
    logic [2:0] ctrl_r;
    logic [31:0] div_r [5];
    logic [3:0] frac_r;
    logic [2:0] fine_r;
    logic [2:0] ph_r;
    logic [7:0] started_r;
    logic [7:0] tap_r;
    logic [4:0] dclk_r;
    logic [2:0] sy_r [2];
    logic [1:0] filt_r;
    logic [15:0] scnt_r [2];
    cspc_stop_t stop_r;
    cspc_lock_t lst_r;
    logic [15:0] lcnt_r;
    logic lock_r;

    // bus handshake: one wait cycle, then one cycle with waitrequest low
    wire req = avs_read_i | avs_write_i;
    wire wr_acc = avs_write_i & ~wait_r;
    wire run = ~ctrl_r[`CSPC_CTRL_RST];
    wire fine_en = ctrl_r[`CSPC_CTRL_FINE];
    wire int_fb = ctrl_r[`CSPC_CTRL_INTFB];
    logic [31:0] rd_mux;

    // read mux; unmapped offsets read as zero but are still answered
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address_i)
            `CSPC_CTRL: rd_mux = {29'h0, ctrl_r};
            `CSPC_STAT: rd_mux = {26'h0, lst_r, ref_clock_select_i, stop_r, lock_r};
            `CSPC_FRAC: rd_mux = {28'h0, frac_r};
            `CSPC_FINE: rd_mux = {29'h0, fine_r};
            default: begin
                for (int n = 0; n < 5; n++) begin
                    if (avs_address_i == div_addr(n)) begin
                        rd_mux = div_r[n];
                    end
                end
            end
        endcase
    end

    // waitrequest idles high, so a request is never taken in its first cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= ~(req & wait_r);
            if (req & wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // control and setting registers; unmapped writes are dropped
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `CSPC_CTRL_RV;
            frac_r <= `CSPC_FRAC_RV;
            for (int n = 0; n < 4; n++) begin
                div_r[n] <= `CSPC_DIV_RV;
            end
            div_r[4] <= `CSPC_FB_RV;
        end else if (wr_acc) begin
            if (avs_address_i == `CSPC_CTRL) ctrl_r <= avs_writedata_i[2:0];
            if (avs_address_i == `CSPC_FRAC) frac_r <= avs_writedata_i[3:0];
            for (int n = 0; n < 5; n++) begin
                if (avs_address_i == div_addr(n)) div_r[n] <= avs_writedata_i;
            end
        end
    end

    // fine shift only steps from zero; there is no way to load it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fine_r <= 3'h0;
        end else if (!run || !fine_en) begin
            fine_r <= 3'h0;
        end else if (wr_acc && avs_address_i == `CSPC_FINE) begin
            fine_r <= avs_writedata_i[0] ? fine_r + 3'h1 : fine_r - 3'h1;
        end
    end

    // oscillator model: one clk cycle per eighth of a period
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_r <= 3'h0;
            started_r <= 8'h0;
        end else if (!run) begin
            ph_r <= 3'h0;
            started_r <= 8'h0;
        end else begin
            ph_r <= ph_r + 3'h1;
            started_r[ph_r] <= 1'b1;
        end
    end

    // tap k is high for four eighths starting at eighth k, once it has started
    logic [7:0] tap_nxt;
    logic [7:0] tap_rise;
    for (genvar k = 0; k < `CSPC_TAPS; k++) begin : g_tap
        assign tap_rise[k] = run & (ph_r == 3'(k));
        assign tap_nxt[k] = run & (started_r[k] | tap_rise[k]) & (3'(ph_r - 3'(k)) < 3'h4);
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) tap_r <= 8'h0;
        else tap_r <= tap_nxt;
    end

    // counters 0..3 drive the outputs, counter 4 the feedback clock
    for (genvar i = 0; i < 5; i++) begin : g_div
        cspc_div_cfg_t cfg;
        logic [7:0] dly_r;
        logic [7:0] cnt_r;
        logic [2:0] acc_r;
        assign cfg = cfg_of(div_r[i]);
        // only the primary counter adds the fine step and the fraction
        wire [2:0] sel = (i == 0 && fine_en) ? 3'(cfg.tap + fine_r) : cfg.tap;
        wire frac_on = (i == 0) & frac_r[`CSPC_FRAC_EN] & ~fine_en;
        wire [3:0] acc_sum = {1'b0, acc_r} + {1'b0, frac_r[2:0]};
        wire [8:0] period = {1'b0, cfg.div} + {8'h0, frac_on & acc_sum[3]};
        wire last = ({1'b0, cnt_r} + 9'h1) >= period;
        wire rise = tap_rise[sel];
        // a zero high count keeps the output low for the whole period
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                dly_r <= 8'h0;
                cnt_r <= 8'h0;
                acc_r <= 3'h0;
                dclk_r[i] <= 1'b0;
            end else if (!run) begin
                dly_r <= cfg.dly;
                cnt_r <= 8'h0;
                acc_r <= 3'h0;
                dclk_r[i] <= 1'b0;
            end else if (rise) begin
                if (dly_r != 8'h0) begin
                    dly_r <= dly_r - 8'h1;
                end else begin
                    dclk_r[i] <= cnt_r < cfg.high;
                    cnt_r <= last ? 8'h0 : cnt_r + 8'h1;
                    if (last && frac_on) acc_r <= acc_sum[2:0];
                end
            end
        end
    end

    // select goes straight to the mux; the muxed clock alone is sampled
    wire ref_mux = ref_clock_select_i ? reference_clock_input1_i : reference_clock_input0_i;
    // internal feedback ignores the pin, so no phase tie to the input is kept
    wire fb_src = int_fb ? dclk_r[4] : feedback_clock_in_i;
    wire [1:0] raw = {fb_src, ref_mux};
    logic [1:0] edge_seen;
    for (genvar c = 0; c < 2; c++) begin : g_mon
        wire agree = sy_r[c][1] == sy_r[c][2];
        assign edge_seen[c] = agree & sy_r[c][2] & ~filt_r[c];
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sy_r[c] <= 3'h0;
                filt_r[c] <= 1'b0;
                scnt_r[c] <= 16'h0;
            end else begin
                sy_r[c] <= {sy_r[c][1:0], raw[c]};
                if (agree) filt_r[c] <= sy_r[c][2];
                // an edge restarts the watchdog and so clears the flag
                if (edge_seen[c]) scnt_r[c] <= 16'h0;
                else if (scnt_r[c] != 16'(STOP_CYC)) scnt_r[c] <= scnt_r[c] + 16'h1;
            end
        end
    end

    // lock: a run of reference edges with both clocks alive; loss sticks until reset
    cspc_lock_t lst_nxt;
    always_comb begin
        lst_nxt = lst_r;
        case (lst_r)
            CSPC_ACQ: if (lcnt_r == 16'(LOCK_EDGES)) lst_nxt = CSPC_LOCK_INDICATION;
            CSPC_LOCK_INDICATION: if (stop_r.in_stop | stop_r.fb_stop) lst_nxt = CSPC_LOST;
            CSPC_LOST: lst_nxt = CSPC_LOST;
            default: lst_nxt = CSPC_ACQ;
        endcase
        if (!run) lst_nxt = CSPC_ACQ;
    end
    // flags are registered first so lock never reacts to a single unfiltered sample
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_r <= '0;
            lst_r <= CSPC_ACQ;
            lcnt_r <= 16'h0;
            lock_r <= 1'b0;
        end else begin
            stop_r.in_stop <= scnt_r[0] == 16'(STOP_CYC);
            stop_r.fb_stop <= scnt_r[1] == 16'(STOP_CYC);
            lst_r <= lst_nxt;
            lock_r <= lst_nxt == CSPC_LOCK_INDICATION;
            if (!run || lst_r != CSPC_ACQ || stop_r != '0) lcnt_r <= 16'h0;
            else if (edge_seen[0] && lcnt_r != 16'(LOCK_EDGES)) lcnt_r <= lcnt_r + 16'h1;
        end
    end

    // every output comes straight from a flop
    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o = rdata_r;
    assign osc_tap_o = tap_r;
    assign output_divider_clk_o = dclk_r[3:0];
    assign feedback_clock_out_o = dclk_r[4];
    assign lock_indication_o = lock_r;
    assign input_clock_stopped_flag_o = stop_r.in_stop;
    assign feedback_clock_stopped_flag_o = stop_r.fb_stop;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_TAP_ORDER: assert property ($rose(started_r[1]) |-> started_r[0])
        else $error("tap 1 started before tap 0");
    AST_TAP_LEVEL: assert property (run && ph_r == 3'h2 |=> tap_r[2] && !tap_r[6])
        else $error("tap levels wrong in eighth 2");
    AST_RESET_IDLE: assert property (!run |=> !lock_r && dclk_r == 5'h0)
        else $error("lock or divider active during reset");
    AST_IN_STOP: assert property (scnt_r[0] == 16'(STOP_CYC) |=> stop_r.in_stop)
        else $error("input stopped flag missing");
    AST_FB_STOP: assert property (scnt_r[1] == 16'(STOP_CYC) |=> stop_r.fb_stop)
        else $error("feedback stopped flag missing");
    AST_UNLOCK: assert property (lock_r && stop_r != '0 |=> !lock_r)
        else $error("lock held with a clock missing");
    AST_LOST_HOLD: assert property (lst_r == CSPC_LOST && run |=> !lock_r [*2])
        else $error("lock regained without reset");
    AST_FINE_ZERO: assert property ($rose(run) |-> fine_r == 3'h0)
        else $error("fine shift not zero at start");
    AST_DLY_HOLD: assert property (run && g_div[3].dly_r != 8'h0 |-> !dclk_r[3])
        else $error("output toggled during delay");
    COV_LOCK: cover property (run ##1 lock_r);
    COV_LOSS: cover property (lock_r ##1 !lock_r && run);
    COV_FRAC: cover property (g_div[0].frac_on && g_div[0].acc_sum[3]);
    COV_REF_SWITCH: cover property (run && $changed(ref_clock_select_i));
endmodule // cspc_top
`default_nettype wire

/* File: tb/cspc_fab_model.sv */
`timescale 1ns/1ns
`default_nettype none
// fabric side: two references and an external feedback clock, each low while stopped
module cspc_fab_model (
    // run controls from the bench
    input wire logic [2:0] run_i,
    // clocks towards the synthesizer
    output logic [2:0] clk_o
);
    // first reference, period unrelated to the bus clock so sampling phases drift
    always begin
        clk_o[0] = 1'b0;
        #110;
        clk_o[0] = run_i[0];
        #110;
    end
    // second reference at another rate
    always begin
        clk_o[1] = 1'b0;
        #160;
        clk_o[1] = run_i[1];
        #160;
    end
    // feedback at the first reference rate, shifted, so both detector inputs match
    always begin
        clk_o[2] = 1'b0;
        #73;
        clk_o[2] = run_i[2];
        #147;
    end
endmodule // cspc_fab_model
`default_nettype wire

/* File: tb/clock_synth_phase_counters_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cspc_regs.svh"
module clock_synth_phase_counters_bench import cspc_pkg::*;;
    // bus clock, bus and pin stimulus
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wt;
    logic sel = 1'b0;
    logic [2:0] run = 3'h7;
    logic [2:0] fck;
    logic [7:0] taps;
    logic [3:0] outs;
    logic fbo;
    logic lock;
    logic ins;
    logic fbs;
    logic [31:0] v;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int r1 [12];
    int r2 [12];
    int f1 [12];
    int len;
    always #25 clk_i = ~clk_i;
    // a small lock count keeps lock detection short; the stop count equals the default of 32
    cspc_top #(.STOP_CYC(32), .LOCK_EDGES(4)) DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .reference_clock_input0_i(fck[0]),
        .reference_clock_input1_i(fck[1]), .ref_clock_select_i(sel),
        .feedback_clock_in_i(fck[2]), .osc_tap_o(taps), .output_divider_clk_o(outs),
        .feedback_clock_out_o(fbo), .lock_indication_o(lock),
        .input_clock_stopped_flag_o(ins), .feedback_clock_stopped_flag_o(fbs));
    cspc_fab_model FAB (.run_i(run), .clk_o(fck));
    // verdict, reached from the main sequence or the hang guard
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the thousand or so cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low; read data taken at that edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        do @(posedge clk_i); while (wt !== 1'b0);
        v = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, v, e);
    endtask
    // let the filtered clocks settle, pulse the synth reset, wait bounded for lock
    task automatic resync(input logic [31:0] c);
        int n;
        n = 0;
        repeat (12) @(posedge clk_i);
        bus(1'b1, `CSPC_CTRL, c | 32'h1);
        bus(1'b1, `CSPC_CTRL, c);
        while (lock !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    // first rise, second rise and first fall of taps and divider outputs
    task automatic trace(input int n);
        logic [11:0] p;
        logic [11:0] c;
        p = 12'h0;
        foreach (r1[i]) begin
            r1[i] = 0;
            r2[i] = 0;
            f1[i] = 0;
        end
        for (int t = 1; t <= n; t++) begin
            @(posedge clk_i);
            c = {outs, taps};
            for (int i = 0; i < 12; i++) begin
                if (c[i] && !p[i] && r1[i] == 0) r1[i] = t;
                else if (c[i] && !p[i] && r2[i] == 0) r2[i] = t;
                if (!c[i] && p[i] && f1[i] == 0) f1[i] = t;
            end
            p = c;
        end
    endtask
    // cycles from the first to the ninth rising edge of bit b of {feedback, outputs}
    task automatic span(input int b);
        logic [4:0] c;
        logic p;
        int n;
        int t;
        int t1;
        p = 1'b1;
        n = 0;
        t = 0;
        t1 = 0;
        len = 0;
        while (n < 9 && t < 400) begin
            @(posedge clk_i);
            t++;
            c = {fbo, outs};
            if (c[b] && !p) begin
                n++;
                if (n == 1) t1 = t;
                len = t - t1;
            end
            p = c[b];
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        // reset values; an unmapped word ignores writes and reads zero
        bus(1'b1, 6'h3c, 32'hffff_ffff);
        rchk("ctrl", `CSPC_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) rchk("div", 6'(`CSPC_DIV0 + 4 * i), `CSPC_DIV_RV);
        rchk("fb", `CSPC_FB, `CSPC_FB_RV);
        rchk("fine", `CSPC_FINE, 32'h0);
        rchk("stat", `CSPC_STAT, 32'h0);
        rchk("unmapped", 6'h3c, 32'h0);
        $display("test reset_values done");
        // div2 on taps 0 and 4, div3 plain and delayed by one output cycle
        bus(1'b1, `CSPC_DIV0, 32'h0000_0102);
        bus(1'b1, 6'h0c, 32'h0004_0102);
        bus(1'b1, 6'h10, 32'h0000_0203);
        bus(1'b1, 6'h14, 32'h0300_0203);
        check("idle", {19'h0, outs, taps, lock}, 32'h0);
        bus(1'b1, `CSPC_CTRL, 32'h0);
        trace(80);
        for (int k = 1; k < 8; k++) check("tap start", 32'(r1[k] - r1[0]), 32'(k));
        for (int k = 0; k < 8; k++) check("tap period", 32'(r2[k] - r1[k]), 32'h8);
        check("tap high", 32'(f1[3] - r1[3]), 32'h4);
        check("out0 period", 32'(r2[8] - r1[8]), 32'h10);
        check("out1 lag", 32'(r1[9] - r1[8]), 32'h4);
        check("out2 period", 32'(r2[10] - r1[10]), 32'h18);
        check("out2 high", 32'(f1[10] - r1[10]), 32'h10);
        check("out3 lag", 32'(r1[11] - r1[10]), 32'h18);
        check("out3 period", 32'(r2[11] - r1[11]), 32'h18);
        rchk("stat lock_indication", `CSPC_STAT, 32'h11);
        $display("test dividers done");
        // reference lost and returned: lock stays low until a synth reset
        run[0] <= 1'b0;
        repeat (60) @(posedge clk_i);
        check("in stop", {30'h0, fbs, ins}, 32'h1);
        rchk("stat lost", `CSPC_STAT, 32'h22);
        run[0] <= 1'b1;
        repeat (20) @(posedge clk_i);
        check("in stop clear", {30'h0, ins, lock}, 32'h0);
        resync(32'h0);
        check("relock", {31'h0, lock}, 32'h1);
        // feedback lost
        run[2] <= 1'b0;
        repeat (60) @(posedge clk_i);
        check("fb stop", {30'h0, fbs, ins}, 32'h2);
        check("fb lock", {31'h0, lock}, 32'h0);
        run[2] <= 1'b1;
        resync(32'h0);
        check("fb relock", {31'h0, lock}, 32'h1);
        $display("test stopped_clocks done");
        // run-time switch to the second reference; the first no longer matters
        sel <= 1'b1;
        bus(1'b0, `CSPC_STAT, 32'h0);
        check("select", v & 32'h8, 32'h8);
        resync(32'h0);
        check("sel lock", {31'h0, lock}, 32'h1);
        run[0] <= 1'b0;
        repeat (60) @(posedge clk_i);
        check("unselected", {30'h0, ins, lock}, 32'h1);
        run[0] <= 1'b1;
        $display("test ref_select done");
        // internal feedback ignores the stopped feedback pin
        bus(1'b1, `CSPC_FB, 32'h0000_0102);
        resync(32'h2);
        run[2] <= 1'b0;
        repeat (60) @(posedge clk_i);
        check("internal fb", {30'h0, fbs, lock}, 32'h1);
        $display("test internal_feedback done");
        // fractional word on the primary, fine steps cleared by synth reset
        bus(1'b1, `CSPC_FRAC, 32'hb);
        rchk("frac", `CSPC_FRAC, 32'hb);
        // eight primary periods of 2 and 3/8 oscillator periods make 19 of them
        span(0);
        check("out0 frac span", 32'(len), 32'h98);
        span(1);
        check("out1 integer span", 32'(len), 32'h80);
        span(4);
        check("fb counter span", 32'(len), 32'h80);
        bus(1'b1, `CSPC_CTRL, 32'h6);
        bus(1'b1, `CSPC_FINE, 32'h1);
        bus(1'b1, `CSPC_FINE, 32'h1);
        rchk("fine steps", `CSPC_FINE, 32'h2);
        bus(1'b1, `CSPC_FINE, 32'h0);
        rchk("fine down", `CSPC_FINE, 32'h1);
        bus(1'b1, `CSPC_CTRL, 32'h7);
        rchk("fine zero", `CSPC_FINE, 32'h0);
        $display("test fine_shift done");
        end_sim();
    end
endmodule // clock_synth_phase_counters_bench
`default_nettype wire
